// >>> hdl/bsc_cfg.svh
`ifndef BSC_CFG_SVH
`define BSC_CFG_SVH

// Instruction field widths
`define BSC_PC_W        10
`define BSC_PCL_W       8
`define BSC_PCH_W       2
`define BSC_FILE_W      6
`define BSC_BIT_W       3
`define BSC_DATA_W      8

// Reset values
`define BSC_PC_RST      10'h000
`define BSC_SP_RST      0

// Default stack depth
`define BSC_STK_DEPTH   8

`endif

// >>> hdl/bsc_pkg.sv
`default_nettype none
package bsc_pkg;

  // Operation class handed over by the core decoder
  typedef enum logic [2:0] {
    BSC_OP_OTHER     = 3'h0,
    BSC_OP_SKIP_CLR  = 3'h1,
    BSC_OP_SKIP_SET  = 3'h2,
    BSC_OP_CALL_IMM  = 3'h3,
    BSC_OP_CALL_TBL  = 3'h4
  } bsc_op_t;

  // Sequencer states, Gray along run -> flush -> run
  typedef enum logic [0:0] {
    BSC_ST_RUN   = 1'b0,
    BSC_ST_FLUSH = 1'b1
  } bsc_state_t;

endpackage
`default_nettype wire

// >>> hdl/bsc_stack_mem.sv
`include "bsc_cfg.svh"
`default_nettype none
module bsc_stack_mem #(
  parameter int DEPTH = `BSC_STK_DEPTH,
  parameter int AW    = $clog2(DEPTH),
  parameter int DW    = `BSC_PC_W
) (
  // Clock
  input  wire logic          i_clk,
  // Write port
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [DW-1:0] i_wdata,
  // Read port
  input  wire logic [AW-1:0] i_raddr,
  output logic      [DW-1:0] o_rdata
);

  logic [DW-1:0] mem_ff [DEPTH];
  logic [DW-1:0] rdata_ff;

  // Entries need no reset; the pointer defines which are live
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem_ff[i_waddr] <= i_wdata;
    end
    rdata_ff <= mem_ff[i_raddr];
  end

  assign o_rdata = rdata_ff;

endmodule
`default_nettype wire

// >>> hdl/bsc_unit.sv
// Notes on behaviour
// RL1: A clear-skip that sees the chosen bit at 0 squashes the already fetched next instruction.
// RL2: A set-skip that sees the chosen bit at 1 squashes the already fetched next instruction.
// RL3: A bit-test skip costs one cycle without a skip and two cycles with one.
// RL4: Skips take a 6-bit file address (0 to 63) and a 3-bit bit position (0 to 7).
// RL5: Both calls push the address after the call, the current PC plus one, onto the stack.
// RL6: The immediate call loads its 8-bit operand into PC[7:0] and the high buffer into PC[9:8].
// RL7: The table call loads bits 1:0 of the table high pointer into PC[9:8].
// RL8: The table call loads the working register into PC[7:0] and takes two cycles.
// RL9: Each call writes the stack entry at the current pointer, then bumps the pointer by one.
// RL10: The immediate call also takes two cycles, and no skip or call touches any status flag.
// RL11: A squashed instruction does nothing but advance the PC by one.
`include "bsc_cfg.svh"
`default_nettype none
module bsc_unit
  import bsc_pkg::*;
#(
  parameter int STK_DEPTH = `BSC_STK_DEPTH,
  parameter int SP_W      = $clog2(STK_DEPTH)
) (
  // Clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_srst,
  // Instruction in execute
  input  wire logic                   i_exec,
  input  wire bsc_op_t                i_op,
  input  wire logic [`BSC_FILE_W-1:0] i_file_addr,
  input  wire logic [`BSC_BIT_W-1:0]  i_bit_pos,
  input  wire logic [`BSC_DATA_W-1:0] i_file_data,
  input  wire logic [`BSC_PCL_W-1:0]  i_imm,
  // Core registers feeding call targets
  input  wire logic [`BSC_PCH_W-1:0]  i_program_counter_high_buffer,
  input  wire logic [`BSC_DATA_W-1:0] i_table_high_pointer,
  input  wire logic [`BSC_DATA_W-1:0] i_working_register,
  // Program flow
  output logic      [`BSC_PC_W-1:0]   o_pc,
  output logic                        o_squash,
  output logic      [`BSC_FILE_W-1:0] o_file_addr,
  // Stack
  output logic      [SP_W-1:0]        o_sp,
  output logic      [`BSC_PC_W-1:0]   o_stack_top,
  // Status flag write strobe, never raised by this unit
  output logic                        o_flag_we
);

  typedef struct packed {
    bsc_state_t             st;
    logic [`BSC_PC_W-1:0]   pc;
    logic [SP_W-1:0]        sp;
    logic                   squash;
    logic [`BSC_FILE_W-1:0] faddr;
    logic                   flag_we;
  } bsc_regs_t;

  bsc_regs_t            cur_ff;
  bsc_regs_t            nxt_ff;
  logic                 push;
  logic [`BSC_PC_W-1:0] ret_addr;

  // Pick one bit out of a file register
  function automatic logic bit_pick(input logic [`BSC_DATA_W-1:0] data,
                                    input logic [`BSC_BIT_W-1:0]  pos);
    bit_pick = data[pos];
  endfunction

  // Whether an operation is one of the two calls
  function automatic logic is_call(input bsc_op_t op);
    is_call = (op == BSC_OP_CALL_IMM) || (op == BSC_OP_CALL_TBL);
  endfunction

  // Whether a skip operation takes its skip
  function automatic logic skip_taken(input bsc_op_t                op,
                                      input logic [`BSC_DATA_W-1:0] data,
                                      input logic [`BSC_BIT_W-1:0]  pos);
    skip_taken = ((op == BSC_OP_SKIP_CLR) && !bit_pick(data, pos)) ||
                 ((op == BSC_OP_SKIP_SET) &&  bit_pick(data, pos));
  endfunction

  // Live instruction: executing, out of reset and not the squashed slot;
  // the reset term keeps a call in a reset cycle from writing the stack
  logic live;
  assign live     = i_exec && !i_srst && (cur_ff.st == BSC_ST_RUN);
  assign ret_addr = cur_ff.pc + `BSC_PC_W'(1);                           // RL5
  assign push     = live && is_call(i_op);

  // Next-state logic
  always_comb begin
    nxt_ff         = cur_ff;
    nxt_ff.flag_we = 1'b0;                                               // RL10
    nxt_ff.squash  = 1'b0;
    nxt_ff.faddr   = i_file_addr;                                        // RL4
    case (cur_ff.st)
      BSC_ST_RUN: begin
        if (i_exec) begin
          nxt_ff.pc = ret_addr;
          if (skip_taken(i_op, i_file_data, i_bit_pos)) begin
            // Fetched successor becomes a no-op in the next slot
            nxt_ff.st     = BSC_ST_FLUSH;                                // RL1 RL2 RL3
            nxt_ff.squash = 1'b1;
          end else if (i_op == BSC_OP_CALL_IMM) begin
            nxt_ff.pc     = {i_program_counter_high_buffer, i_imm};      // RL6
            nxt_ff.sp     = cur_ff.sp + SP_W'(1);                        // RL9
            nxt_ff.st     = BSC_ST_FLUSH;                                // RL10
            nxt_ff.squash = 1'b1;
          end else if (i_op == BSC_OP_CALL_TBL) begin
            nxt_ff.pc     = {i_table_high_pointer[`BSC_PCH_W-1:0],      // RL7
                             i_working_register};                        // RL8
            nxt_ff.sp     = cur_ff.sp + SP_W'(1);                        // RL9
            nxt_ff.st     = BSC_ST_FLUSH;                                // RL8
            nxt_ff.squash = 1'b1;
          end
        end
      end
      BSC_ST_FLUSH: begin
        // Squashed slot: only the sequential step, no stack or flag effect
        if (i_exec) begin
          nxt_ff.pc = ret_addr;                                          // RL11
          nxt_ff.st = BSC_ST_RUN;                                        // RL3
        end else begin
          // Marker stands until the discarded instruction turns up
          nxt_ff.squash = 1'b1;                                          // RL1 RL2
        end
      end
      default: begin
        nxt_ff.st = BSC_ST_RUN;
      end
    endcase
  end

  // State register
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      cur_ff.st      <= BSC_ST_RUN;
      cur_ff.pc      <= `BSC_PC_RST;
      cur_ff.sp      <= SP_W'(`BSC_SP_RST);
      cur_ff.squash  <= 1'b0;
      cur_ff.faddr   <= '0;
      cur_ff.flag_we <= 1'b0;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  // Return stack; a full stack wraps, as the pointer has no guard
  bsc_stack_mem #(
    .DEPTH (STK_DEPTH),
    .AW    (SP_W),
    .DW    (`BSC_PC_W)
  ) u_stack (
    .i_clk   (i_clk),
    .i_we    (push),                                                     // RL9
    .i_waddr (cur_ff.sp),
    .i_wdata (ret_addr),                                                 // RL5
    .i_raddr (nxt_ff.sp - SP_W'(1)),
    .o_rdata (o_stack_top)
  );

  // Outputs straight from the state register
  assign o_pc        = cur_ff.pc;
  assign o_sp        = cur_ff.sp;
  assign o_squash    = cur_ff.squash;
  assign o_file_addr = cur_ff.faddr;
  assign o_flag_we   = cur_ff.flag_we;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  sequence s_live_skip_clr;
    live && i_op == BSC_OP_SKIP_CLR && !i_file_data[i_bit_pos];
  endsequence

  sequence s_live_skip_set;
    live && i_op == BSC_OP_SKIP_SET && i_file_data[i_bit_pos];
  endsequence

  sequence s_squash_slot;
    o_squash && o_pc == $past(o_pc) + `BSC_PC_W'(1);
  endsequence

  a_skip_clr_squash: assert property (s_live_skip_clr |=> s_squash_slot) // RL1
    else $error("clear-skip did not squash next slot");
  a_skip_set_squash: assert property (s_live_skip_set |=> s_squash_slot) // RL2
    else $error("set-skip did not squash next slot");
  a_skip_not_taken: assert property (live && (i_op == BSC_OP_SKIP_CLR ||
      i_op == BSC_OP_SKIP_SET) && !skip_taken(i_op, i_file_data, i_bit_pos)
      |=> !o_squash) // RL3
    else $error("skip not taken yet slot squashed");
  a_call_imm_pc: assert property (live && i_op == BSC_OP_CALL_IMM
      |=> o_pc == {$past(i_program_counter_high_buffer), $past(i_imm)}) // RL6
    else $error("immediate call target wrong");
  a_call_tbl_pc: assert property (live && i_op == BSC_OP_CALL_TBL
      |=> o_pc[9:8] == $past(i_table_high_pointer[1:0])
          && o_pc[7:0] == $past(i_working_register)) // RL7
    else $error("table call target wrong");
  a_call_two_cyc: assert property (push |=> o_squash ##1 !o_squash || !$past(i_exec)) // RL8
    else $error("call did not take two cycles");
  a_call_push_ret: assert property (push ##1 1'b1 ##1 (nxt_ff.sp == cur_ff.sp)
      |-> o_stack_top == $past(cur_ff.pc, 2) + `BSC_PC_W'(1)) // RL5
    else $error("pushed return address wrong");
  a_call_sp_inc: assert property (push |=> o_sp == $past(o_sp) + SP_W'(1)) // RL9
    else $error("stack pointer did not advance");
  a_no_flag_write: assert property (i_exec |=> !o_flag_we) // RL10
    else $error("status flag written");
  a_squash_quiet: assert property (o_squash && i_exec
      |-> !push ##1 o_sp == $past(o_sp) && !o_squash) // RL11
    else $error("squashed slot had a side effect");

  // Squash slot: the marker waits for an instruction, then steps the PC once
  a_squash_hold: assert property (o_squash && !i_exec |=> o_squash) // RL1
    else $error("pending squash dropped before its slot");
  a_flush_pc_step: assert property (o_squash && i_exec
      |=> o_pc == $past(o_pc) + `BSC_PC_W'(1)) // RL11
    else $error("squashed slot did not step the PC");
  // Empty cycles leave program flow and stack alone
  a_idle_hold: assert property (!i_exec |=> $stable(o_pc) && $stable(o_sp)) // RL11
    else $error("state moved without an instruction");
  // Reset must win over any instruction in the same cycle, so no disable here
  a_reset_state: assert property (disable iff (1'b0) i_srst
      |=> o_pc == `BSC_PC_RST && o_sp == '0 && !o_squash && !o_flag_we) // RL10
    else $error("outputs not at reset values");

endmodule
`default_nettype wire

// >>> dv/bsc_file_model.sv
`default_nettype none
module bsc_file_model (
  // Clock
  input  wire logic       i_clk,
  // File register lookup
  input  wire logic [5:0] i_addr,
  output logic      [7:0] o_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] drift_ff = 8'h00;
  // Contents drift each cycle so both bit values reach every position;
  // moved on the falling edge so the data stand still across the sampling edge
  always @(negedge i_clk) begin
    drift_ff <= drift_ff + 8'h3b;
  end
  // Same-cycle read, as the core hands file data with the instruction
  assign o_data = {i_addr, i_addr[1:0]} ^ drift_ff;
endmodule
`default_nettype wire

// >>> dv/bit_skip_and_call_unit_bench.sv
`default_nettype none
module bit_skip_and_call_unit_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import bsc_pkg::*;
  logic i_clk = 1'b0, i_srst = 1'b1, i_exec = 1'b0;
  bsc_op_t i_op = BSC_OP_OTHER;
  logic [5:0] i_file_addr = 6'h00;
  logic [2:0] i_bit_pos = 3'h0;
  logic [7:0] i_file_data, i_imm = 8'h00, i_table_high_pointer = 8'h00;
  logic [7:0] i_working_register = 8'h00;
  logic [1:0] i_program_counter_high_buffer = 2'h0;
  logic [9:0] o_pc, o_stack_top;
  logic [5:0] o_file_addr;
  logic [2:0] o_sp;
  logic o_squash, o_flag_we;
  int mismatches = 0, checks = 0, cycles = 0;
  int pc = 0, sp = 0, sq = 0, fa = 0, fa_chk = 0, age = 0, seed;
  int stk[8];
  bit vld[8];
  // 4 ns period
  always #2 i_clk = ~i_clk;
  bsc_unit DUT (.i_clk(i_clk), .i_srst(i_srst), .i_exec(i_exec), .i_op(i_op),
    .i_file_addr(i_file_addr), .i_bit_pos(i_bit_pos), .i_file_data(i_file_data),
    .i_imm(i_imm), .i_program_counter_high_buffer(i_program_counter_high_buffer),
    .i_table_high_pointer(i_table_high_pointer), .i_working_register(i_working_register),
    .o_pc(o_pc), .o_squash(o_squash), .o_file_addr(o_file_addr), .o_sp(o_sp),
    .o_stack_top(o_stack_top), .o_flag_we(o_flag_we));
  bsc_file_model FILES (.i_clk(i_clk), .i_addr(i_file_addr), .o_data(i_file_data));
  task automatic stop_test();
    if (mismatches == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Hang guard, about two thirds above the planned run
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      stop_test();
    end
  end
  initial begin
    seed = $urandom(58243);
    repeat (12) @(negedge i_clk);
    for (int n = 0; n < 3000; n++) begin
      @(negedge i_clk);
      if (n > 0) begin
        check(16'(o_pc), 16'(pc));
        check(16'(o_sp), 16'(sp));
        check(16'(o_squash), 16'(sq));
        check(16'(o_flag_we), 16'h0000);
        if (fa_chk != 0) check(16'(o_file_addr), 16'(fa));
        if (age >= 1 && vld[(sp + 7) % 8]) check(16'(o_stack_top), 16'(stk[(sp + 7) % 8]));
      end
      // Random instruction stream with gaps and one mid-run reset
      i_srst = (n == 0 || n == 1500 || n == 1501);
      i_exec = ($urandom_range(0, 7) != 0);
      i_op = bsc_op_t'(3'($urandom_range(0, 4)));
      i_file_addr = 6'($urandom_range(0, 63));
      i_bit_pos = 3'($urandom_range(0, 7));
      i_imm = 8'($urandom);
      i_program_counter_high_buffer = 2'($urandom);
      i_table_high_pointer = 8'($urandom);
      i_working_register = 8'($urandom);
      @(posedge i_clk);
      // Reference step: same inputs the unit samples at this edge
      age++;
      fa_chk = 0;
      if (i_srst) begin
        pc = 0;
        sp = 0;
        sq = 0;
        age = 0;
      end else if (i_exec) begin
        if (sq != 0) begin
          pc = (pc + 1) % 1024;
          sq = 0;
        end else begin
          case (i_op)
            BSC_OP_SKIP_CLR, BSC_OP_SKIP_SET: begin
              sq = (i_file_data[i_bit_pos] == (i_op == BSC_OP_SKIP_SET));
              pc = (pc + 1) % 1024;
              fa = i_file_addr;
              fa_chk = 1;
            end
            BSC_OP_CALL_IMM, BSC_OP_CALL_TBL: begin
              stk[sp] = (pc + 1) % 1024;
              vld[sp] = 1'b1;
              if (i_op == BSC_OP_CALL_IMM) pc = {i_program_counter_high_buffer, i_imm};
              else pc = {i_table_high_pointer[1:0], i_working_register};
              sp = (sp + 1) % 8;
              sq = 1;
              age = 0;
            end
            default: pc = (pc + 1) % 1024;
          endcase
        end
      end
    end
    stop_test();
  end
endmodule
`default_nettype wire
